/* rtl/tbmc_ctrl.v */
/*
 * Temperature and battery monitor controller: configuration registers,
 * measurement sequencer, supply and battery routing, result readback.
 * Assumes a byte-wide register port, the power mode on a 2-bit input,
 * and an analog converter with a start/done handshake.
 */
// Summary of operation
// - Manual trigger starts one measurement only when period field is zero.
// - Manual trigger is held, not run, in sleep and display-only modes; it runs once they are left.
// - Supply select 1 digital, 0 RTC battery; sleep/display force battery.
// - Battery select: 1 main battery, 0 RTC battery.
// - Oscillator test field must be 00; nonzero runs oscillator continuously.
// - Result read as high byte plus three low bits at top of next byte.
// - Battery result is a read-only byte at its own address.
// - With battery enable set, each temperature run also measures battery.
// - Load bit applies 100 uA load to selected battery in mission mode.
// - Battery load never applied in brownout, display-only or sleep.
// - Period 0 manual, 1-6 every 2^(3+n) s, 7 continuous, any mode.
// - Writes to config byte raise pending flag and are blocked up to 6 ms.
// - Sleep/display wake sensor at period rate only; mission/brownout also on command.
`include "tbmc_defines.vh"
`default_nettype none

module tbmc_ctrl #(
	parameter [31:0] COMMIT_CYC = `TBMC_COMMIT_CYC,
	parameter [31:0] SEC_CYC = `TBMC_SEC_CYC
) (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Register port
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output wire [7:0] reg_rdata,
	// Power mode
	input wire [1:0] power_mode,
	// Analog converter
	output reg conv_start,
	output reg conv_battery,
	input wire conv_done,
	input wire [10:0] conv_temp,
	input wire [7:0] conv_batt,
	// Analog controls
	output reg sensor_supply_digital,
	output reg battery_select_main,
	output reg battery_load_on,
	output reg osc_free_run,
	output reg [1:0] osc_test_mode
);

localparam ST_IDLE = 2'h0;
localparam ST_TEMP = 2'h1;
localparam ST_BATT = 2'h2;

reg [7:0] cfg_r;
reg [1:0] osc_test_r;
reg load_r;
reg trig_r;
reg pend_r;
reg [31:0] commit_cnt_r;
reg [31:0] tick_cnt_r;
reg [9:0] sec_cnt_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg manual_r;
reg [1:0] rsel_r;
reg [7:0] rdata_r;
wire [7:0] store_rdata;
wire [2:0] period;
wire low_power;
wire mission;
wire period_due;
wire manual_go;
wire auto_go;
wire wr_cfg;

// ----------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------
function hit;
	input [15:0] a;
	input [15:0] b;
	begin
		hit = (a == b);
	end
endfunction

// Seconds between automatic runs: 2^(3+n)
function [9:0] per_secs;
	input [2:0] p;
	begin
		per_secs = 10'h001 << (3 + p);
	end
endfunction

assign period = cfg_r[2:0];
assign low_power = (power_mode == `TBMC_MODE_SLEEP) ||
	(power_mode == `TBMC_MODE_DISPLAY);
assign mission = (power_mode == `TBMC_MODE_MISSION);
assign wr_cfg = reg_wr && hit(reg_addr, `TBMC_ADDR_CFG);

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
always @(posedge clock or negedge nrst)
begin
	if (!nrst)
	begin
		cfg_r <= `TBMC_CFG_RST;
		osc_test_r <= 2'h0;
		load_r <= 1'b0;
		pend_r <= 1'b0;
		commit_cnt_r <= 32'h0;
	end
	else
	begin
		// A second write while committing is dropped, not queued
		if (wr_cfg && !pend_r)
		begin
			cfg_r <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
			pend_r <= 1'b1;
			commit_cnt_r <= COMMIT_CYC - 32'h1;
		end
		else if (pend_r)
		begin
			if (commit_cnt_r == 32'h0)
				pend_r <= 1'b0;
			else
				commit_cnt_r <= commit_cnt_r - 32'h1;
		end
		if (reg_wr && hit(reg_addr, `TBMC_ADDR_OSC_TEST))
			osc_test_r <= reg_wdata[1:0];
		if (reg_wr && hit(reg_addr, `TBMC_ADDR_LOAD))
			load_r <= reg_wdata[`TBMC_BIT_LOAD];
	end
end

// ----------------------------------------------------------------------
// Period timer
// ----------------------------------------------------------------------
assign period_due = (period != `TBMC_PER_MANUAL) &&
	(period != `TBMC_PER_CONT) && (sec_cnt_r >= per_secs(period) - 10'h1) &&
	(tick_cnt_r == SEC_CYC - 32'h1);

always @(posedge clock or negedge nrst)
begin
	if (!nrst)
	begin
		tick_cnt_r <= 32'h0;
		sec_cnt_r <= 10'h000;
	end
	else if (period == `TBMC_PER_MANUAL || period == `TBMC_PER_CONT)
	begin
		tick_cnt_r <= 32'h0;
		sec_cnt_r <= 10'h000;
	end
	else if (tick_cnt_r == SEC_CYC - 32'h1)
	begin
		tick_cnt_r <= 32'h0;
		sec_cnt_r <= period_due ? 10'h000 : sec_cnt_r + 10'h001;
	end
	else
		tick_cnt_r <= tick_cnt_r + 32'h1;
end

// ----------------------------------------------------------------------
// Measurement sequencer
// ----------------------------------------------------------------------
// Automatic runs in every mode; manual only at period 0 outside sleep/display
assign auto_go = period_due || (period == `TBMC_PER_CONT);
assign manual_go = trig_r && !manual_r && (period == `TBMC_PER_MANUAL) &&
	!low_power;

always @*
begin
	state_nxt = state_r;
	case (state_r)
		ST_IDLE:
			if (manual_go || auto_go)
				state_nxt = ST_TEMP;
		ST_TEMP:
			if (conv_done)
				state_nxt = cfg_r[`TBMC_BIT_BMEAS] ? ST_BATT : ST_IDLE;
		ST_BATT:
			if (conv_done)
				state_nxt = ST_IDLE;
		default:
			state_nxt = ST_IDLE;
	endcase
end

always @(posedge clock or negedge nrst)
begin
	if (!nrst)
	begin
		state_r <= ST_IDLE;
		trig_r <= 1'b0;
		manual_r <= 1'b0;
		conv_start <= 1'b0;
		conv_battery <= 1'b0;
	end
	else
	begin
		state_r <= state_nxt;
		conv_start <= 1'b0;
		if (state_r == ST_IDLE && state_nxt == ST_TEMP)
		begin
			manual_r <= manual_go;
			conv_start <= 1'b1;
			conv_battery <= 1'b0;
		end
		if (state_r == ST_TEMP && state_nxt == ST_BATT)
		begin
			conv_start <= 1'b1;
			conv_battery <= 1'b1;
		end
		// Completion of a manual run clears the trigger; a new write in that cycle wins
		if (reg_wr && hit(reg_addr, `TBMC_ADDR_TRIG))
			trig_r <= reg_wdata[`TBMC_BIT_TRIG];
		else if (manual_r && state_r != ST_IDLE && state_nxt == ST_IDLE)
			trig_r <= 1'b0;
		if (state_r != ST_IDLE && state_nxt == ST_IDLE)
			manual_r <= 1'b0;
	end
end

// ----------------------------------------------------------------------
// Analog controls
// ----------------------------------------------------------------------
always @(posedge clock or negedge nrst)
begin
	if (!nrst)
	begin
		sensor_supply_digital <= 1'b0;
		battery_select_main <= 1'b0;
		battery_load_on <= 1'b0;
		osc_free_run <= 1'b0;
		osc_test_mode <= 2'h0;
	end
	else
	begin
		sensor_supply_digital <= cfg_r[`TBMC_BIT_PWR] && !low_power;
		battery_select_main <= cfg_r[`TBMC_BIT_BSEL];
		battery_load_on <= load_r && mission;
		osc_free_run <= (osc_test_r != 2'h0);
		osc_test_mode <= osc_test_r;
	end
end

// ----------------------------------------------------------------------
// Readback
// ----------------------------------------------------------------------
tbmc_result_store u_store (
	.clock(clock),
	.nrst(nrst),
	.wr_temp(state_r == ST_TEMP && conv_done),
	.temp_in(conv_temp),
	.wr_batt(state_r == ST_BATT && conv_done),
	.batt_in(conv_batt),
	.rd_sel(hit(reg_addr, `TBMC_ADDR_TEMP_HI) ? 2'h0 :
		hit(reg_addr, `TBMC_ADDR_TEMP_LO) ? 2'h1 :
		hit(reg_addr, `TBMC_ADDR_BATT) ? 2'h2 : 2'h3),
	.rd_data(store_rdata)
);

always @(posedge clock or negedge nrst)
begin
	if (!nrst)
	begin
		rsel_r <= 2'h0;
		rdata_r <= 8'h00;
	end
	else
	begin
		rsel_r <= 2'h0;
		rdata_r <= 8'h00;
		if (reg_rd)
		begin
			if (hit(reg_addr, `TBMC_ADDR_CFG))
				rdata_r <= {cfg_r[7:4], pend_r, cfg_r[2:0]};
			else if (hit(reg_addr, `TBMC_ADDR_OSC_TEST))
				rdata_r <= {6'h00, osc_test_r};
			else if (hit(reg_addr, `TBMC_ADDR_LOAD))
				rdata_r <= {4'h0, load_r, 3'h0};
			else if (hit(reg_addr, `TBMC_ADDR_TRIG))
				rdata_r <= {1'b0, trig_r, 6'h00};
			else if (hit(reg_addr, `TBMC_ADDR_TEMP_HI) ||
				hit(reg_addr, `TBMC_ADDR_TEMP_LO) ||
				hit(reg_addr, `TBMC_ADDR_BATT))
				rsel_r <= 2'h1;
		end
	end
end

assign reg_rdata = (rsel_r == 2'h1) ? store_rdata : rdata_r;

endmodule

`default_nettype wire

/* rtl/tbmc_defines.vh */
/*
 * Constants for the temperature and battery monitor controller: register
 * byte addresses, bit positions, reset values and timing counts.
 * Assumes a 10 MHz clock and byte-wide register access.
 */
`ifndef TBMC_DEFINES_VH
`define TBMC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define TBMC_ADDR_OSC_TEST 16'h2500
`define TBMC_ADDR_LOAD 16'h2704
`define TBMC_ADDR_TEMP_HI 16'h2881
`define TBMC_ADDR_TEMP_LO 16'h2882
`define TBMC_ADDR_BATT 16'h2885
`define TBMC_ADDR_CFG 16'h28a0
`define TBMC_ADDR_TRIG 16'h28b4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TBMC_BIT_LOAD 3
`define TBMC_BIT_BSEL 7
`define TBMC_BIT_PWR 6
`define TBMC_BIT_BMEAS 4
`define TBMC_BIT_PEND 3
`define TBMC_BIT_TRIG 6

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define TBMC_CFG_RST 8'h00
`define TBMC_PER_MANUAL 3'h0
`define TBMC_PER_CONT 3'h7
`define TBMC_MODE_MISSION 2'h0
`define TBMC_MODE_BROWNOUT 2'h1
`define TBMC_MODE_DISPLAY 2'h2
`define TBMC_MODE_SLEEP 2'h3

// ----------------------------------------------------------------------
// Timing: clock 10 MHz, commit time 6 ms, period unit 1 s
// ----------------------------------------------------------------------
`define TBMC_CLK_HZ 10000000
`define TBMC_COMMIT_MS 6
`define TBMC_COMMIT_CYC ((`TBMC_CLK_HZ / 1000) * `TBMC_COMMIT_MS)
`define TBMC_SEC_CYC (`TBMC_CLK_HZ)

`endif

/* rtl/tbmc_result_store.v */
/*
 * Result store: holds the 11-bit temperature and 8-bit battery results.
 * Read data come from a register one cycle after the address.
 * Assumes one writer, the measurement sequencer of the controller.
 */
`default_nettype none

module tbmc_result_store (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Write side
	input wire wr_temp,
	input wire [10:0] temp_in,
	input wire wr_batt,
	input wire [7:0] batt_in,
	// Read side
	input wire [1:0] rd_sel,
	output reg [7:0] rd_data
);

reg [10:0] temp_r;
reg [7:0] batt_r;

always @(posedge clock or negedge nrst)
begin
	if (!nrst)
	begin
		temp_r <= 11'h000;
		batt_r <= 8'h00;
		rd_data <= 8'h00;
	end
	else
	begin
		if (wr_temp)
			temp_r <= temp_in;
		if (wr_batt)
			batt_r <= batt_in;
		// Upper byte, then low bits left-justified so a word read is x32
		case (rd_sel)
			2'h0: rd_data <= temp_r[10:3];
			2'h1: rd_data <= {temp_r[2:0], 5'h00};
			2'h2: rd_data <= batt_r;
			default: rd_data <= 8'h00;
		endcase
	end
end

endmodule

`default_nettype wire

/* test/tbmc_chk.sv */
/* Port checker for tbmc_ctrl.
   Assumes the controller's register port and converter handshake. */
`default_nettype none
module tbmc_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Watched ports
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] power_mode,
	input wire logic conv_start,
	input wire logic conv_battery,
	input wire logic conv_done,
	input wire logic sensor_supply_digital,
	input wire logic battery_load_on,
	input wire logic osc_free_run,
	input wire logic [1:0] osc_test_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// ----
	// Outputs are registered, so a mode must hold two edges
	// ----
	a_load_mission_only: assert property (power_mode != 2'h0 &&
		$past(power_mode) != 2'h0 |-> !battery_load_on)
		else $error("load applied outside mission");
	a_supply_forced_batt: assert property (power_mode[1] &&
		$past(power_mode[1]) |-> !sensor_supply_digital)
		else $error("digital supply in low power mode");
	a_osc_free_run: assert property (reg_wr &&
		reg_addr == 16'h2500 |=> ##1
		osc_test_mode == $past(reg_wdata[1:0], 2) &&
		osc_free_run == ($past(reg_wdata[1:0], 2) != 2'h0))
		else $error("oscillator run flag wrong");
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_temp_lo_pad: assert property (reg_rd &&
		reg_addr == 16'h2882 |=> reg_rdata[4:0] == 5'h00)
		else $error("low result byte padding wrong");
	a_unmapped_zero: assert property (reg_rd &&
		reg_addr == 16'h2883 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_start_one_pulse: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	a_batt_after_temp: assert property (conv_start &&
		conv_battery |-> $past(conv_done) || $past(conv_done, 2))
		else $error("battery start without prior done");
endmodule
bind tbmc_ctrl tbmc_chk i_tbmc_chk (.clock, .nrst, .reg_addr, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata, .power_mode, .conv_start,
	.conv_battery, .conv_done,
	.sensor_supply_digital, .battery_load_on, .osc_free_run,
	.osc_test_mode);
`default_nettype wire

/* test/tbmc_ctrl_bench.sv */
/* Self-checking bench for tbmc_ctrl with a converter responder.
   Assumes short commit and second counts set by parameters. */
`include "tbmc_defines.vh"
`default_nettype none
module tbmc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [1:0] power_mode = 2'h0;
	logic conv_done = 1'b0;
	logic [10:0] conv_temp = 11'h000;
	logic [7:0] conv_batt = 8'h00;
	wire [7:0] reg_rdata;
	wire conv_start, conv_battery, supply_dig, bsel_main, load_on, osc_run;
	wire [1:0] osc_mode;
	int bad_count = 0;
	int cmp_count = 0;
	int n_temp = 0;
	int n_batt = 0;
	int nc, nb;
	logic [15:0] lfsr = 16'h0030;
	logic [10:0] exp_temp;
	logic [7:0] exp_batt, rv, cfg;
	logic batt_r;
	logic [15:0] ra[5] = '{`TBMC_ADDR_CFG, `TBMC_ADDR_LOAD,
		`TBMC_ADDR_OSC_TEST, `TBMC_ADDR_TRIG, 16'h2883};
	always #50 clock = ~clock;
	tbmc_ctrl #(.COMMIT_CYC(8), .SEC_CYC(4)) i_tbmc_ctrl (.clock(clock),
		.nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.power_mode(power_mode), .conv_start(conv_start),
		.conv_battery(conv_battery), .conv_done(conv_done),
		.conv_temp(conv_temp), .conv_batt(conv_batt),
		.sensor_supply_digital(supply_dig), .battery_select_main(bsel_main),
		.battery_load_on(load_on), .osc_free_run(osc_run),
		.osc_test_mode(osc_mode));
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] low_byte(input logic [10:0] t);
		return {t[2:0], 5'h00};
	endfunction
	// ----
	// Converter: answers two edges after each start
	// ----
	always @(posedge clock)
	begin
		if (conv_start)
		begin
			batt_r = conv_battery;
			n_batt += batt_r;
			n_temp += !batt_r;
			lfsr = next_rand(lfsr);
			repeat (2) @(posedge clock);
			#10;
			conv_done = 1'b1;
			conv_temp = lfsr[10:0];
			conv_batt = lfsr[15:8];
			if (batt_r)
				exp_batt = lfsr[15:8];
			else
				exp_temp = lfsr[10:0];
			@(posedge clock);
			#10;
			conv_done = 1'b0;
		end
	end
	task automatic check(input string what, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#10;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clock);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock);
		#10;
		reg_rd = 1'b0;
		rv = reg_rdata;
	endtask
	task automatic wait_clear(input logic [15:0] a, input int b);
		int i = 0;
		rd(a);
		while (rv[b] !== 1'b0 && i < 400)
		begin
			rd(a);
			i++;
		end
		if (rv[b] !== 1'b0)
		begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task automatic mode(input logic [1:0] m);
		@(posedge clock);
		#10;
		power_mode = m;
		repeat (3) @(posedge clock);
		#10;
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clock);
		#10;
		nrst = 1'b1;
		foreach (ra[k])
		begin
			rd(ra[k]);
			check("reset value", rv, 8'h00);
		end
		// Top two bits step through supply and battery choices 00, 01, 01, 10; 11 is never reached
		for (int k = 0; k < 4; k++)
		begin
			lfsr = next_rand(lfsr);
			cfg = {lfsr[1:0] ^ 2'(k), 6'h10};
			wr(`TBMC_ADDR_CFG, cfg);
			wait_clear(`TBMC_ADDR_CFG, 3);
			check("config", rv, cfg);
			check("supply", 8'(supply_dig), 8'(cfg[6]));
			check("battery select", 8'(bsel_main), 8'(cfg[7]));
			nc = n_batt;
			wr(`TBMC_ADDR_TRIG, 8'h40);
			wait_clear(`TBMC_ADDR_TRIG, 6);
			check("battery runs", 8'(n_batt - nc), 8'h01);
			rd(`TBMC_ADDR_TEMP_HI);
			check("temp high", rv, exp_temp[10:3]);
			rd(`TBMC_ADDR_TEMP_LO);
			check("temp low", rv, low_byte(exp_temp));
			rd(`TBMC_ADDR_BATT);
			check("battery", rv, exp_batt);
		end
		// Second write lands while the first is still committing
		wr(`TBMC_ADDR_CFG, 8'h50);
		wr(`TBMC_ADDR_CFG, 8'h80);
		rd(`TBMC_ADDR_CFG);
		check("pending", 8'(rv[3]), 8'h01);
		wait_clear(`TBMC_ADDR_CFG, 3);
		check("dropped write", rv, 8'h50);
		mode(`TBMC_MODE_DISPLAY);
		check("low power supply", 8'(supply_dig), 8'h00);
		nc = n_temp;
		wr(`TBMC_ADDR_TRIG, 8'h40);
		repeat (20) @(posedge clock);
		mode(`TBMC_MODE_SLEEP);
		repeat (20) @(posedge clock);
		check("low power trigger", 8'(n_temp - nc), 8'h00);
		mode(`TBMC_MODE_MISSION);
		wait_clear(`TBMC_ADDR_TRIG, 6);
		check("held trigger", 8'(n_temp - nc), 8'h01);
		wr(`TBMC_ADDR_LOAD, 8'h08);
		rd(`TBMC_ADDR_LOAD);
		check("load reg", rv, 8'h08);
		for (int m = 0; m < 4; m++)
		begin
			mode(2'(m));
			check("load", 8'(load_on), 8'(m == 0));
			check("mode supply", 8'(supply_dig), 8'(m < 2));
		end
		for (int m = 0; m < 4; m++)
		begin
			wr(`TBMC_ADDR_OSC_TEST, 8'(m));
			@(posedge clock);
			#10;
			check("osc mode", 8'(osc_mode), 8'(m));
			check("osc run", 8'(osc_run), 8'(m != 0));
		end
		// Leave the oscillator test field at its normal value
		wr(`TBMC_ADDR_OSC_TEST, 8'h00);
		wr(`TBMC_ADDR_CFG, 8'h01);
		nc = n_temp;
		repeat (200) @(posedge clock);
		nc = n_temp - nc;
		check("auto count", 8'(nc >= 2 && nc <= 4), 8'h01);
		wr(`TBMC_ADDR_CFG, 8'h07);
		mode(`TBMC_MODE_MISSION);
		nc = n_temp;
		nb = n_batt;
		repeat (40) @(posedge clock);
		#10;
		check("continuous", 8'(n_temp - nc >= 5), 8'h01);
		check("battery off", 8'(n_batt - nb), 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
